// ---- pkg/csc_consts.svh ----
// Constants for the charge sequence controller: offsets, fields, reset values, timing.
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CSC_OFS_STATUS 8'h00
`define CSC_OFS_CTRL 8'h01
`define CSC_OFS_FLOAT 8'h02
`define CSC_OFS_ICHG 8'h04
`define CSC_OFS_SPECIAL 8'h05
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CSC_STAT_LSB 4
`define CSC_CTRL_BOOST 0
`define CSC_CTRL_HZ 1
`define CSC_CTRL_TE 3
`define CSC_CTRL_ILIM_LSB 6
`define CSC_FLOAT_LSB 2
`define CSC_ICHG_LSB 4
`define CSC_TERMINATION_CURRENT_CODE_LSB 0
`define CSC_FLOOR_LSB 0
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CSC_RST_CTRL 8'h40
`define CSC_RST_FLOAT 8'h28
`define CSC_RST_ICHG 8'h00
`define CSC_RST_SPECIAL 8'h04
// ----------------------------------------------------------------
// Status codes and decode tables
// ----------------------------------------------------------------
`define CSC_ST_READY 2'h0
`define CSC_ST_CHARGING 2'h1
`define CSC_ST_DONE 2'h2
`define CSC_ST_FAULT 2'h3
`define CSC_FLOAT_MV_A 13'd4100
`define CSC_FLOAT_MV_B 13'd4200
`define CSC_FLOAT_MV_C 13'd4350
`define CSC_FLOAT_MV_D 13'd4400
`define CSC_FLOAT_B_MIN 6'h02
`define CSC_FLOAT_C_MIN 6'h24
`define CSC_FLOAT_D_MIN 6'h2D
// Sense targets in tenths of a millivolt, code 7 first.
`define CSC_ICHG_TABLE {10'd983, 10'd918, 10'd787, 10'd721, 10'd590, 10'd524, 10'd393, 10'd328}
`define CSC_TERMINATION_CURRENT_CODE_TABLE {7'd113, 7'd100, 7'd88, 7'd75, 7'd63, 7'd50, 7'd38, 7'd25}
// Input limit in mA, code 3 first; zero means no limit.
`define CSC_ILIM_TABLE {10'd0, 10'd800, 10'd500, 10'd150}
`define CSC_FLOOR_TABLE {13'd4800, 13'd4670, 13'd4590, 13'd4520, 13'd4442, 13'd4366, 13'd4290, 13'd4214}
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CSC_CLK_HZ 10000000
`define CSC_QUAL_MS 25
`define CSC_WAKE_MIN 90
`define CSC_SAFETY_HOURS 12
`define CSC_WDOG_S 32
`endif

// ---- pkg/csc_pkg.sv ----
// Types shared by the charge sequence controller modules.
package csc_pkg;
	typedef enum logic [6:0] {
		CSC_IDLE = 7'h01,
		CSC_QUAL = 7'h02,
		CSC_PRE = 7'h04,
		CSC_PWM = 7'h08,
		CSC_DONE = 7'h10,
		CSC_SUSP = 7'h20,
		CSC_TOUT = 7'h40
	} csc_state_e;
	typedef logic [15:0] csc_sec_t;
endpackage

// ---- pkg/csc_tick_if.sv ----
// Carrier of the one-second enable between the timebase and the sequencer.
`timescale 1ns/10ps
`default_nettype none
interface csc_tick_if;
	logic sec_tick;
	modport src (output sec_tick);
	modport dst (input sec_tick);
endinterface
`default_nettype wire

// ---- rtl/csc_timebase.sv ----
// One-second enable divider for the safety and watchdog timers.
`timescale 1ns/10ps
`default_nettype none
`include "csc_consts.svh"
module csc_timebase #(
	parameter int SEC_CYCLES = `CSC_CLK_HZ
) (
	input wire logic clock,
	input wire logic rst,
	csc_tick_if.src tick
);
	localparam int CW = $clog2(SEC_CYCLES);
	localparam logic [CW-1:0] LAST = CW'(SEC_CYCLES - 1);
	logic [CW-1:0] count;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count <= '0;
			tick.sec_tick <= 1'b0;
		end else begin
			tick.sec_tick <= (count == LAST);
			count <= (count == LAST) ? '0 : count + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/csc_charge_seq.sv ----
// Charge sequencing, supervision, watchdog and register file of the charger.
`timescale 1ns/10ps
`default_nettype none
`include "csc_consts.svh"
// Functional notes
// - With supply invalid, boost allowed only when high-impedance select is clear.
// - Below precharge threshold use linear pre-charge; above it start PWM charging.
// - Termination enabled and current below threshold stops PWM charging.
// - After termination with supply present, status reads charge done, code 10.
// - Termination disabled keeps the charger in voltage regulation indefinitely; here the 12-hour safety timer still ends PWM charging.
// - Float code bits 7:2 of register 2 decode to 4.10/4.20/4.35/4.40 V.
// - Charge current code bits 6:4 of register 4 give 32.8 to 98.3 mV.
// - Termination code bits 2:0 of register 4 give 2.5 to 11.3 mV.
// - Input limit bits 7:6 of register 1: 150, 500, 800 mA, unlimited.
// - Input floor bits 2:0 of register 5, 4.214 to 4.8 V, reset 100.
// - Ramp current until a limit or the floor is hit, then hold.
// - Wake-up charge still below 3.1 V after 90 minutes turns off for good.
// - 12-hour timer turns off; resume only when float exceeds battery by 100 mV.
// - Removing and reconnecting the adapter clears both safety timers.
// - In boost, no register access for 32 s restores defaults and leaves boost.
// - Every start or restart needs supply inside limits for 25 ms continuously.
// - Battery below float minus recharge margin starts a new charge cycle.
// - Charging is suspended while die temperature exceeds the thermal limit.
// - Supply below undervoltage threshold terminates charging.
// - Supply above overvoltage threshold suspends charging.
// - After overvoltage, resume only after 150 mV drop and requalification.
// - Charging status is reported in bits 5:4 of register 0.
// - Mode comes from boost select, high-impedance select and the disable pin.
module csc_charge_seq #(
	parameter int QUAL_CYCLES = `CSC_QUAL_MS * (`CSC_CLK_HZ / 1000),
	parameter int SEC_CYCLES = `CSC_CLK_HZ
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic cmp_below_precharge,
	input wire logic cmp_below_term,
	input wire logic cmp_supply_uv,
	input wire logic cmp_supply_ov,
	input wire logic cmp_ov_released,
	input wire logic cmp_over_thermal,
	input wire logic cmp_below_wake,
	input wire logic cmp_recharge,
	input wire logic cmp_resume_margin,
	input wire logic cmp_at_floor,
	input wire logic cmp_at_limit,
	input wire logic disable_pin,
	output logic precharge_en,
	output logic pwm_en,
	output logic ramp_up,
	output logic boost_en,
	output logic [12:0] float_mv,
	output logic [9:0] charge_sense,
	output logic [6:0] term_sense,
	output logic [9:0] input_limit_ma,
	output logic [12:0] floor_mv
);
	// ----------------------------------------------------------------
	// Constants
	// ----------------------------------------------------------------
	localparam int NSYNC = 12;
	localparam int QW = $clog2(QUAL_CYCLES + 1);
	localparam logic [QW-1:0] QUAL_LAST = QW'(QUAL_CYCLES - 1);
	localparam csc_pkg::csc_sec_t WAKE_SECS = 16'(`CSC_WAKE_MIN * 60);
	localparam csc_pkg::csc_sec_t SAFETY_SECS = 16'(`CSC_SAFETY_HOURS * 3600);
	localparam logic [5:0] WDOG_SECS = 6'(`CSC_WDOG_S);
	localparam logic [79:0] ICHG_TABLE = `CSC_ICHG_TABLE;
	localparam logic [55:0] TERMINATION_CURRENT_CODE_TABLE = `CSC_TERMINATION_CURRENT_CODE_TABLE;
	localparam logic [39:0] ILIM_TABLE = `CSC_ILIM_TABLE;
	localparam logic [103:0] FLOOR_TABLE = `CSC_FLOOR_TABLE;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	assign raw_in = {disable_pin, cmp_at_limit, cmp_at_floor, cmp_resume_margin,
		cmp_recharge, cmp_below_wake, cmp_over_thermal, cmp_ov_released,
		cmp_supply_ov, cmp_supply_uv, cmp_below_term, cmp_below_precharge};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					sync_a[gi] <= 1'b0;
					sync_b[gi] <= 1'b0;
				end else begin
					sync_a[gi] <= raw_in[gi];
					sync_b[gi] <= sync_a[gi];
				end
			end
		end
	endgenerate
	logic s_pre, s_term, s_uv, s_ov, s_ovrel, s_hot, s_wake;
	logic s_rech, s_resume, s_floor, s_limit, s_dis;
	assign {s_dis, s_limit, s_floor, s_resume, s_rech, s_wake, s_hot, s_ovrel,
		s_ov, s_uv, s_term, s_pre} = sync_b;

	// ----------------------------------------------------------------
	// Timebase
	// ----------------------------------------------------------------
	csc_tick_if tick_bus ();
	csc_timebase #(.SEC_CYCLES(SEC_CYCLES)) u_timebase (
		.clock(clock),
		.rst(rst),
		.tick(tick_bus.src)
	);
	logic sec_tick;
	assign sec_tick = tick_bus.sec_tick;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [7:0] ctrl_reg;
	logic [7:0] float_reg;
	logic [7:0] ichg_reg;
	logic [7:0] special_reg;
	logic [1:0] status_code;
	logic wdog_fire;
	logic boost_drop;
	logic supply_ok;
	logic te;
	logic hz;
	logic boost_sel;
	assign te = ctrl_reg[`CSC_CTRL_TE];
	assign hz = ctrl_reg[`CSC_CTRL_HZ];
	assign boost_sel = ctrl_reg[`CSC_CTRL_BOOST];
	assign supply_ok = !s_uv && !s_ov;
	// Boost falls away on a fault-like loss of permission; the select bit follows it.
	assign boost_drop = boost_en && (hz || s_dis || supply_ok);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_reg <= `CSC_RST_CTRL;
			float_reg <= `CSC_RST_FLOAT;
			ichg_reg <= `CSC_RST_ICHG;
			special_reg <= `CSC_RST_SPECIAL;
		end else if (wdog_fire) begin
			ctrl_reg <= `CSC_RST_CTRL;
			float_reg <= `CSC_RST_FLOAT;
			ichg_reg <= `CSC_RST_ICHG;
			special_reg <= `CSC_RST_SPECIAL;
		end else if (reg_wr) begin
			case (reg_addr)
				`CSC_OFS_CTRL: ctrl_reg <= reg_wdata;
				`CSC_OFS_FLOAT: float_reg <= reg_wdata;
				`CSC_OFS_ICHG: ichg_reg <= reg_wdata;
				`CSC_OFS_SPECIAL: special_reg <= reg_wdata;
				default: ctrl_reg <= ctrl_reg;
			endcase
		end else if (boost_drop) begin
			ctrl_reg[`CSC_CTRL_BOOST] <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`CSC_OFS_STATUS: reg_rdata <= 8'(status_code) << `CSC_STAT_LSB;
				`CSC_OFS_CTRL: reg_rdata <= ctrl_reg;
				`CSC_OFS_FLOAT: reg_rdata <= float_reg;
				`CSC_OFS_ICHG: reg_rdata <= ichg_reg;
				`CSC_OFS_SPECIAL: reg_rdata <= special_reg;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Limit decoders
	// ----------------------------------------------------------------
	logic [5:0] float_code;
	logic [2:0] ichg_code;
	logic [2:0] termination_current_code_code;
	logic [1:0] ilim_code;
	logic [2:0] floor_code;
	assign float_code = float_reg[`CSC_FLOAT_LSB +: 6];
	assign ichg_code = ichg_reg[`CSC_ICHG_LSB +: 3];
	assign termination_current_code_code = ichg_reg[`CSC_TERMINATION_CURRENT_CODE_LSB +: 3];
	assign ilim_code = ctrl_reg[`CSC_CTRL_ILIM_LSB +: 2];
	assign floor_code = special_reg[`CSC_FLOOR_LSB +: 3];

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			float_mv <= `CSC_FLOAT_MV_B;
			charge_sense <= 10'h000;
			term_sense <= 7'h00;
			input_limit_ma <= 10'h000;
			floor_mv <= 13'h0000;
		end else begin
			if (float_code >= `CSC_FLOAT_D_MIN) begin
				float_mv <= `CSC_FLOAT_MV_D;
			end else if (float_code >= `CSC_FLOAT_C_MIN) begin
				float_mv <= `CSC_FLOAT_MV_C;
			end else if (float_code >= `CSC_FLOAT_B_MIN) begin
				float_mv <= `CSC_FLOAT_MV_B;
			end else begin
				float_mv <= `CSC_FLOAT_MV_A;
			end
			charge_sense <= ICHG_TABLE[ichg_code * 10 +: 10];
			term_sense <= TERMINATION_CURRENT_CODE_TABLE[termination_current_code_code * 7 +: 7];
			input_limit_ma <= ILIM_TABLE[ilim_code * 10 +: 10];
			floor_mv <= FLOOR_TABLE[floor_code * 13 +: 13];
		end
	end

	// ----------------------------------------------------------------
	// Charge sequencer
	// ----------------------------------------------------------------
	csc_pkg::csc_state_e state;
	logic [QW-1:0] qual_count;
	logic qual_done;
	csc_pkg::csc_sec_t wake_secs;
	csc_pkg::csc_sec_t safety_secs;
	logic wake_dead;
	logic charge_allowed;
	assign qual_done = (qual_count == QUAL_LAST) && supply_ok;
	// Disable pin stops charging; high-impedance select only gates boost.
	assign charge_allowed = !s_dis && !wake_dead;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			qual_count <= '0;
		end else if (state != csc_pkg::CSC_QUAL || !supply_ok) begin
			qual_count <= '0;
		end else if (qual_count != QUAL_LAST) begin
			qual_count <= qual_count + 1'b1;
		end
	end

	// A dead wake-up charge is only cleared by removing the adapter.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wake_dead <= 1'b0;
		end else if (s_uv) begin
			wake_dead <= 1'b0;
		end else if (state == csc_pkg::CSC_PRE && wake_secs >= WAKE_SECS && s_wake) begin
			wake_dead <= 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wake_secs <= '0;
			safety_secs <= '0;
		end else if (s_uv) begin
			wake_secs <= '0;
			safety_secs <= '0;
		end else if (state == csc_pkg::CSC_TOUT && s_resume) begin
			safety_secs <= '0;
		end else if (sec_tick) begin
			if (state == csc_pkg::CSC_PRE && wake_secs < WAKE_SECS) begin
				wake_secs <= wake_secs + 1'b1;
			end
			if (state == csc_pkg::CSC_PWM && safety_secs < SAFETY_SECS) begin
				safety_secs <= safety_secs + 1'b1;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= csc_pkg::CSC_IDLE;
		end else begin
			case (state)
				csc_pkg::CSC_IDLE: begin
					if (supply_ok && charge_allowed) begin
						state <= csc_pkg::CSC_QUAL;
					end
				end
				csc_pkg::CSC_QUAL: begin
					if (!charge_allowed) begin
						state <= csc_pkg::CSC_IDLE;
					end else if (qual_done && !s_hot) begin
						state <= s_pre ? csc_pkg::CSC_PRE : csc_pkg::CSC_PWM;
					end
				end
				csc_pkg::CSC_PRE, csc_pkg::CSC_PWM: begin
					if (s_uv || !charge_allowed) begin
						state <= csc_pkg::CSC_IDLE;
					end else if (s_ov || s_hot) begin
						state <= csc_pkg::CSC_SUSP;
					end else if (state == csc_pkg::CSC_PRE) begin
						if (wake_secs >= WAKE_SECS && s_wake) begin
							state <= csc_pkg::CSC_IDLE;
						end else if (!s_pre) begin
							state <= csc_pkg::CSC_PWM;
						end
					end else if (safety_secs >= SAFETY_SECS) begin
						state <= csc_pkg::CSC_TOUT;
					end else if (te && s_term) begin
						state <= csc_pkg::CSC_DONE;
					end
				end
				csc_pkg::CSC_SUSP: begin
					if (s_uv || !charge_allowed) begin
						state <= csc_pkg::CSC_IDLE;
					end else if (!s_hot && !s_ov && s_ovrel) begin
						state <= csc_pkg::CSC_QUAL;
					end
				end
				csc_pkg::CSC_DONE: begin
					if (s_uv || !charge_allowed) begin
						state <= csc_pkg::CSC_IDLE;
					end else if (s_rech) begin
						state <= csc_pkg::CSC_QUAL;
					end
				end
				csc_pkg::CSC_TOUT: begin
					if (s_uv) begin
						state <= csc_pkg::CSC_IDLE;
					end else if (s_resume && charge_allowed) begin
						state <= csc_pkg::CSC_QUAL;
					end
				end
				default: state <= csc_pkg::CSC_IDLE;
			endcase
		end
	end

	always_comb begin
		case (state)
			csc_pkg::CSC_PRE, csc_pkg::CSC_PWM, csc_pkg::CSC_SUSP: status_code = `CSC_ST_CHARGING;
			csc_pkg::CSC_DONE: status_code = `CSC_ST_DONE;
			csc_pkg::CSC_TOUT: status_code = `CSC_ST_FAULT;
			default: status_code = wake_dead ? `CSC_ST_FAULT : `CSC_ST_READY;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			precharge_en <= 1'b0;
			pwm_en <= 1'b0;
			ramp_up <= 1'b0;
		end else begin
			precharge_en <= (state == csc_pkg::CSC_PRE);
			pwm_en <= (state == csc_pkg::CSC_PWM);
			ramp_up <= (state == csc_pkg::CSC_PWM) && !s_limit && !s_floor;
		end
	end

	// ----------------------------------------------------------------
	// Boost control and watchdog
	// ----------------------------------------------------------------
	logic [5:0] wdog_secs;
	assign wdog_fire = boost_en && sec_tick && (wdog_secs == WDOG_SECS - 6'h01);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			boost_en <= 1'b0;
		end else begin
			boost_en <= boost_sel && !hz && !s_dis && !supply_ok && !wdog_fire;
		end
	end

	// Any access restarts the count, so a host polling faster than 32 s keeps boost up.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wdog_secs <= 6'h00;
		end else if (!boost_en || reg_wr || reg_rd || wdog_fire) begin
			wdog_secs <= 6'h00;
		end else if (sec_tick) begin
			wdog_secs <= wdog_secs + 6'h01;
		end
	end
endmodule
`default_nettype wire

// ---- verification/csc_charge_seq_monitor.sv ----
// Concurrent checks on the ports of the charge sequence controller.
`timescale 1ns/10ps
`default_nettype none
module csc_charge_seq_monitor #(
	parameter int QUAL_CYCLES = 20
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic cmp_supply_uv,
	input wire logic cmp_supply_ov,
	input wire logic cmp_over_thermal,
	input wire logic precharge_en,
	input wire logic pwm_en,
	input wire logic boost_en,
	input wire logic [12:0] float_mv,
	input wire logic [9:0] charge_sense,
	input wire logic [6:0] term_sense,
	input wire logic [9:0] input_limit_ma,
	input wire logic [12:0] floor_mv
);
	localparam logic [9:0] CHG [8] = '{10'd328, 10'd393, 10'd524, 10'd590, 10'd721, 10'd787, 10'd918, 10'd983};
	localparam logic [6:0] TRM [8] = '{7'd25, 7'd38, 7'd50, 7'd63, 7'd75, 7'd88, 7'd100, 7'd113};
	localparam logic [9:0] LIM [4] = '{10'd150, 10'd500, 10'd800, 10'd0};
	localparam logic [12:0] FLR [8] = '{13'd4214, 13'd4290, 13'd4366, 13'd4442, 13'd4520, 13'd4590, 13'd4670, 13'd4800};
	logic [7:0] wd1;
	logic [7:0] wd2;
	int ok_cnt;
	function automatic logic [12:0] fmv(input logic [7:0] w);
		if (w[7:2] < 6'h02) return 13'd4100;
		if (w[7:2] < 6'h24) return 13'd4200;
		if (w[7:2] < 6'h2D) return 13'd4350;
		return 13'd4400;
	endfunction
	// Write data two cycles back lines up with the decoded outputs.
	always_ff @(posedge clock) begin
		wd1 <= reg_wdata;
		wd2 <= wd1;
	end
	// Run of cycles with the raw supply inside its window; saturates to stay small.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ok_cnt <= 0;
		end else if (cmp_supply_uv || cmp_supply_ov) begin
			ok_cnt <= 0;
		end else if (ok_cnt < QUAL_CYCLES) begin
			ok_cnt <= ok_cnt + 1;
		end
	end
	default clocking mon_clk @(posedge clock);
	endclocking
	default disable iff (rst);
	float_decode_a: assert property (reg_wr && reg_addr == 8'h02 && !boost_en
		|-> ##2 float_mv == fmv(wd2)) else $error("float voltage decode wrong");
	charge_decode_a: assert property (reg_wr && reg_addr == 8'h04 && !boost_en
		|-> ##2 charge_sense == CHG[wd2[6:4]]) else $error("charge target decode wrong");
	term_decode_a: assert property (reg_wr && reg_addr == 8'h04 && !boost_en
		|-> ##2 term_sense == TRM[wd2[2:0]]) else $error("termination decode wrong");
	limit_decode_a: assert property (reg_wr && reg_addr == 8'h01 && !boost_en
		|-> ##2 input_limit_ma == LIM[wd2[7:6]]) else $error("input limit decode wrong");
	floor_decode_a: assert property (reg_wr && reg_addr == 8'h05 && !boost_en
		|-> ##2 floor_mv == FLR[wd2[2:0]]) else $error("input floor decode wrong");
	qual_wait_a: assert property ($rose(pwm_en || precharge_en)
		|-> $past(ok_cnt, 3) >= QUAL_CYCLES - 3) else $error("charge started unqualified");
	hot_stop_a: assert property (cmp_over_thermal [*5] |-> !pwm_en && !precharge_en)
		else $error("charging while hot");
	ov_stop_a: assert property (cmp_supply_ov [*5] |-> !pwm_en && !precharge_en)
		else $error("charging above overvoltage");
	hz_boost_a: assert property (reg_wr && reg_addr == 8'h01 && reg_wdata[1] |-> ##2 !boost_en)
		else $error("boost on with high impedance");
	sync_delay_a: assert property ($rose(cmp_over_thermal) && pwm_en |=> pwm_en [*3])
		else $error("comparator used unsynchronised");
endmodule
bind csc_charge_seq csc_charge_seq_monitor #(.QUAL_CYCLES(QUAL_CYCLES)) i_mon (
	.clock, .rst, .reg_addr, .reg_wr, .reg_wdata, .cmp_supply_uv, .cmp_supply_ov,
	.cmp_over_thermal, .precharge_en, .pwm_en, .boost_en, .float_mv, .charge_sense,
	.term_sense, .input_limit_ma, .floor_mv
);
`default_nettype wire

// ---- verification/csc_stage_model.sv ----
// Behavioural model of the analog power stage and its comparators.
`timescale 1ns/10ps
`default_nettype none
module csc_stage_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic [9:0] lv,
	input wire logic pwm_en,
	input wire logic ramp_up,
	output logic [9:0] cmp,
	output logic cmp_at_limit
);
	logic [3:0] ramp_cnt;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cmp <= 10'h014;
		end else begin
			cmp <= lv;
		end
	end
	// Current only grows while ramping, so the limit is reached after eight steps.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ramp_cnt <= 4'h0;
		end else if (!pwm_en) begin
			ramp_cnt <= 4'h0;
		end else if (ramp_up && ramp_cnt != 4'h8) begin
			ramp_cnt <= ramp_cnt + 4'h1;
		end
	end
	assign cmp_at_limit = (ramp_cnt == 4'h8);
endmodule
`default_nettype wire

// ---- verification/test_charge_sequence_controller.sv ----
// Self-checking bench for the charge sequence controller.
`timescale 1ns/10ps
`default_nettype none
module test_charge_sequence_controller;
	localparam int QUAL = 20;
	localparam int SEC = 50;
	localparam int PRE = 0, TERM = 1, UV = 2, OV = 3, OVR = 4, HOT = 5, RCH = 7, FLR = 9;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [9:0] lv = 10'h014;
	logic [9:0] cmp;
	logic cmp_at_limit;
	logic disable_pin = 1'b0;
	logic precharge_en;
	logic pwm_en;
	logic ramp_up;
	logic boost_en;
	logic [12:0] float_mv;
	logic [9:0] charge_sense;
	logic [6:0] term_sense;
	logic [9:0] input_limit_ma;
	logic [12:0] floor_mv;
	logic [31:0] seed = 32'h61FD;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [9:0] chg_tab [8] = '{10'd328, 10'd393, 10'd524, 10'd590, 10'd721, 10'd787, 10'd918, 10'd983};
	logic [6:0] trm_tab [8] = '{7'd25, 7'd38, 7'd50, 7'd63, 7'd75, 7'd88, 7'd100, 7'd113};
	logic [9:0] lim_tab [4] = '{10'd150, 10'd500, 10'd800, 10'd0};
	logic [12:0] flr_tab [8] = '{13'd4214, 13'd4290, 13'd4366, 13'd4442, 13'd4520, 13'd4590, 13'd4670, 13'd4800};
	logic [5:0] corner [9] = '{6'h00, 6'h01, 6'h02, 6'h23, 6'h24, 6'h2C, 6'h2D, 6'h3E, 6'h3F};
	csc_charge_seq #(.QUAL_CYCLES(QUAL), .SEC_CYCLES(SEC)) i_dut (
		.clock, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.cmp_below_precharge(cmp[0]), .cmp_below_term(cmp[1]), .cmp_supply_uv(cmp[2]),
		.cmp_supply_ov(cmp[3]), .cmp_ov_released(cmp[4]), .cmp_over_thermal(cmp[5]),
		.cmp_below_wake(cmp[6]), .cmp_recharge(cmp[7]), .cmp_resume_margin(cmp[8]),
		.cmp_at_floor(cmp[9]), .cmp_at_limit, .disable_pin, .precharge_en, .pwm_en,
		.ramp_up, .boost_en, .float_mv, .charge_sense, .term_sense, .input_limit_ma, .floor_mv
	);
	csc_stage_model i_stage (.clock, .rst, .lv, .pwm_en, .ramp_up, .cmp, .cmp_at_limit);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [12:0] exp_float(input logic [5:0] c);
		if (c < 6'h02) return 13'd4100;
		if (c < 6'h24) return 13'd4200;
		if (c < 6'h2D) return 13'd4350;
		return 13'd4400;
	endfunction
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Strobes drop for a cycle so back-to-back calls never retrigger in one step.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		tick(1);
		reg_wr = 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		tick(1);
		chk({8'h00, reg_rdata}, {8'h00, exp});
		reg_rd = 1'b0;
		tick(1);
	endtask
	task automatic wait_drv(input logic [1:0] v);
		int n;
		n = 0;
		while ({precharge_en, pwm_en} !== v && n < 300) begin
			tick(1);
			n++;
		end
		chk({14'h0000, precharge_en, pwm_en}, {14'h0000, v});
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		forever begin
			#50 clock = ~clock;
		end
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			results();
		end
	end
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		int i;
		logic [5:0] fc;
		repeat (6) @(posedge clock);
		#1;
		rst = 1'b0;
		tick(2);
		chk(float_mv, 13'd4200);
		chk(charge_sense, 10'd328);
		chk(term_sense, 7'd25);
		chk(input_limit_ma, 10'd500);
		chk(floor_mv, 13'd4520);
		rd(8'h01, 8'h40);
		rd(8'h02, 8'h28);
		rd(8'h04, 8'h00);
		rd(8'h05, 8'h04);
		rd(8'h03, 8'h00);
		wr(8'h00, 8'hFF);
		rd(8'h00, 8'h00);
		for (i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			fc = (i < 9) ? corner[i] : seed[5:0];
			wr(8'h02, {fc, seed[7:6]});
			wr(8'h04, seed[15:8]);
			wr(8'h05, seed[23:16]);
			wr(8'h01, {seed[25:24], 6'h00});
			tick(2);
			chk(float_mv, exp_float(fc));
			chk(charge_sense, chg_tab[seed[14:12]]);
			chk(term_sense, trm_tab[seed[10:8]]);
			chk(floor_mv, flr_tab[seed[18:16]]);
			chk(input_limit_ma, lim_tab[seed[25:24]]);
		end
		rd(8'h02, {fc, seed[7:6]});
		lv[UV] = 1'b0;
		lv[PRE] = 1'b1;
		tick(10);
		chk({14'h0000, precharge_en, pwm_en}, 16'h0000);
		wait_drv(2'b10);
		rd(8'h00, 8'h10);
		lv[PRE] = 1'b0;
		wait_drv(2'b01);
		tick(2);
		chk(ramp_up, 1'b1);
		tick(30);
		chk(ramp_up, 1'b0);
		lv[TERM] = 1'b1;
		tick(60);
		chk(pwm_en, 1'b1);
		wr(8'h01, 8'h08);
		wait_drv(2'b00);
		rd(8'h00, 8'h20);
		lv[TERM] = 1'b0;
		lv[FLR] = 1'b1;
		lv[RCH] = 1'b1;
		wait_drv(2'b01);
		tick(2);
		chk(ramp_up, 1'b0);
		lv[FLR] = 1'b0;
		tick(5);
		chk(ramp_up, 1'b1);
		lv[RCH] = 1'b0;
		lv[HOT] = 1'b1;
		wait_drv(2'b00);
		lv[HOT] = 1'b0;
		wait_drv(2'b01);
		lv[OV] = 1'b1;
		lv[OVR] = 1'b0;
		wait_drv(2'b00);
		lv[OV] = 1'b0;
		tick(60);
		chk(pwm_en, 1'b0);
		lv[OVR] = 1'b1;
		wait_drv(2'b01);
		disable_pin = 1'b1;
		wait_drv(2'b00);
		disable_pin = 1'b0;
		wait_drv(2'b01);
		lv[UV] = 1'b1;
		wait_drv(2'b00);
		rd(8'h00, 8'h00);
		wr(8'h01, 8'h41);
		tick(4);
		chk(boost_en, 1'b1);
		wr(8'h01, 8'h43);
		tick(3);
		chk(boost_en, 1'b0);
		rd(8'h01, 8'h42);
		wr(8'h01, 8'h41);
		tick(SEC * 24);
		rd(8'h03, 8'h00);
		tick(SEC * 24);
		chk(boost_en, 1'b1);
		for (i = 0; i < SEC * 12 && boost_en === 1'b1; i++) begin
			tick(1);
		end
		chk(boost_en, 1'b0);
		rd(8'h01, 8'h40);
		rd(8'h02, 8'h28);
		results();
	end
endmodule
`default_nettype wire
